// ===== core/sbsram_core.sv
`default_nettype none
// Behaviour
// - Selected only with primary_select_n low, depth_select_hi high and depth_select_lo_n low.
// - All lanes are written when global_write_n is low, or with the gate low and every lane low.
// - After a write the data bus stays undriven until a read is started by either address strobe.
// - On leaving sleep the data bus stays undriven until a normal access starts.
// - Data is driven only while outEnable_n is low; raising it releases the bus at the next clock edge.
module sbsram_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic primary_select_n,
    input wire logic depth_select_hi,
    input wire logic depth_select_lo_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [sbsram_pkg::LANES-1:0] lane_write_n,
    input wire logic outEnable_n,
    input wire logic sleep_request,
    input wire logic [sbsram_pkg::ADDR_W-1:0] addr,
    input wire logic [sbsram_pkg::DATA_W-1:0] dataIn,
    output logic [sbsram_pkg::DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic writeStall,
    output logic powerReady,
    output logic sleepViolation
);
    logic [sbsram_pkg::DATA_W-1:0] mem [sbsram_pkg::DEPTH];
    logic selected, strobe, startRead, startWrite;
    logic [sbsram_pkg::LANES-1:0] laneEn;
    logic fifoInReady, fifoOutValid;
    logic [sbsram_pkg::FIFO_W-1:0] fifoOut;
    sbsram_pkg::sbs_state_t state_r, state_nxt;
    logic [sbsram_pkg::DATA_W-1:0] dataOut_r, dataOut_nxt;
    logic dataOe_r, dataOe_nxt, stall_r, stall_nxt, viol_r, viol_nxt;
    logic [sbsram_pkg::PWR_CNT_W-1:0] pwrCnt_r, pwrCnt_nxt;
    logic ready_r, ready_nxt;

    // Lane enables for a write; zero means no write at all.
    function automatic logic [sbsram_pkg::LANES-1:0] lanes_of(
        input logic gw, input logic gate, input logic [sbsram_pkg::LANES-1:0] bw);
        logic [sbsram_pkg::LANES-1:0] r;
        r = sbsram_pkg::LANES_NONE;
        if (!gw) begin
            r = sbsram_pkg::LANES_ALL;
        end else if (!gate) begin
            r = ~bw;
        end
        return r;
    endfunction

    //----------------------------------------
    // Access decode
    //----------------------------------------
    // select decode.
    assign selected = !primary_select_n && depth_select_hi && !depth_select_lo_n;
    assign strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    assign laneEn = lanes_of(global_write_n, byte_write_gate_n, lane_write_n);
    assign startWrite = selected && strobe && !sleep_request && (laneEn != sbsram_pkg::LANES_NONE)
        && ready_r;
    assign startRead = selected && strobe && !sleep_request && (laneEn == sbsram_pkg::LANES_NONE)
        && ready_r;

    //----------------------------------------
    // Write buffer
    //----------------------------------------
    // Writes are queued and retired into the array one per cycle.
    sbsram_fifo #(.WIDTH(sbsram_pkg::FIFO_W), .DEPTH(sbsram_pkg::FIFO_D)) uFifo (
        .clk(clk),
        .srst(srst),
        .inValid(startWrite),
        .inReady(fifoInReady),
        .inData({addr, dataIn, laneEn}),
        .outValid(fifoOutValid),
        .outReady(1'b1),
        .outData(fifoOut)
    );

    // Array update per enabled lane.
    always_ff @(posedge clk) begin
        if (fifoOutValid) begin
            for (int i = 0; i < sbsram_pkg::LANES; i++) begin
                if (fifoOut[i]) begin
                    mem[fifoOut[sbsram_pkg::FIFO_W-1 -: sbsram_pkg::ADDR_W]]
                        [i*sbsram_pkg::LANE_W +: sbsram_pkg::LANE_W] <=
                        fifoOut[sbsram_pkg::LANES + i*sbsram_pkg::LANE_W +: sbsram_pkg::LANE_W];
                end
            end
        end
    end

    //----------------------------------------
    // Output drive and power-up
    //----------------------------------------
    // Next state of the data bus drive.
    always_comb begin
        state_nxt = state_r;
        dataOut_nxt = dataOut_r;
        pwrCnt_nxt = pwrCnt_r;
        ready_nxt = ready_r;
        stall_nxt = !fifoInReady;
        // Any sleep request seen while selected is flagged, asleep or not.
        viol_nxt = sleep_request && selected;
        if (pwrCnt_r == sbsram_pkg::PWR_CNT_W'(sbsram_pkg::POWER_UP_CYC - 1)) begin
            ready_nxt = 1'b1;
        end else begin
            pwrCnt_nxt = sbsram_pkg::PWR_CNT_W'(pwrCnt_r + 1'b1);
        end
        case (state_r)
            sbsram_pkg::SBS_SLEEP: begin
                // stay undriven after sleep until an access.
                if (!sleep_request && startRead) begin
                    state_nxt = sbsram_pkg::SBS_READ;
                end
            end
            default: begin
                if (sleep_request) begin
                    state_nxt = sbsram_pkg::SBS_SLEEP;
                end else if (startWrite) begin
                    state_nxt = sbsram_pkg::SBS_WRITTEN;
                end else if (startRead) begin
                    state_nxt = sbsram_pkg::SBS_READ;
                end
            end
        endcase
        if (startRead) begin
            dataOut_nxt = mem[addr];
        end
        // drive only with output enable low.
        dataOe_nxt = (state_nxt == sbsram_pkg::SBS_READ) && !outEnable_n;
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= sbsram_pkg::SBS_IDLE;
            dataOut_r <= sbsram_pkg::DATA_RST;
            dataOe_r <= 1'b0;
            pwrCnt_r <= '0;
            ready_r <= 1'b0;
            stall_r <= 1'b0;
            viol_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dataOut_r <= dataOut_nxt;
            dataOe_r <= dataOe_nxt;
            pwrCnt_r <= pwrCnt_nxt;
            ready_r <= ready_nxt;
            stall_r <= stall_nxt;
            viol_r <= viol_nxt;
        end
    end

    assign dataOut = dataOut_r;
    assign dataOe = dataOe_r;
    assign writeStall = stall_r;
    assign powerReady = ready_r;
    assign sleepViolation = viol_r;

    //----------------------------------------
    // Assertions
    //----------------------------------------
    sequence s_write_taken;
        startWrite && !startRead;
    endsequence
    sequence s_bus_quiet;
        !dataOe [*1];
    endsequence

    a_deselect_no_drive: assert property (@(posedge clk) disable iff (srst)
        primary_select_n && state_r != sbsram_pkg::SBS_READ |=> !dataOe)
        else $error("Bus driven without a selected read.");
    a_full_write_lanes: assert property (@(posedge clk) disable iff (srst)
        !global_write_n |-> laneEn == sbsram_pkg::LANES_ALL)
        else $error("Global write did not enable all lanes.");
    a_write_then_quiet: assert property (@(posedge clk) disable iff (srst)
        s_write_taken ##1 (!startRead) |=> s_bus_quiet)
        else $error("Bus driven after a write without a new read.");
    a_sleep_needs_deselect: assert property (@(posedge clk) disable iff (srst)
        $rose(sleep_request) && selected |=> sleepViolation)
        else $error("Sleep violation not flagged.");
    a_sleep_exit_quiet: assert property (@(posedge clk) disable iff (srst)
        state_r == sbsram_pkg::SBS_SLEEP && !startRead |=> !dataOe)
        else $error("Bus driven on sleep exit.");
    a_power_wait_held: assert property (@(posedge clk) disable iff (srst)
        !ready_r |-> !startRead && !startWrite)
        else $error("Access taken before power-up wait.");
    a_oe_high_quiet: assert property (@(posedge clk) disable iff (srst)
        outEnable_n |=> !dataOe)
        else $error("Bus driven with output enable high.");
    a_lane_write_mask: assert property (@(posedge clk) disable iff (srst)
        global_write_n && !byte_write_gate_n |-> laneEn == ~lane_write_n)
        else $error("Lane enables do not follow lane writes.");
endmodule
`default_nettype wire

// ===== core/sbsram_pkg.sv
`default_nettype none
package sbsram_pkg;
    // Bus widths of the modelled array.
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int ADDR_W = 6;
    localparam int DEPTH = 64;
    // Write FIFO geometry.
    localparam int FIFO_W = ADDR_W + DATA_W + LANES;
    localparam int FIFO_D = 16;
    // Power-up wait before the first access.
    localparam int CLK_MHZ = 10;
    localparam int POWER_UP_WAIT_MS = 1;
    localparam int POWER_UP_CYC = POWER_UP_WAIT_MS * 1000 * CLK_MHZ;
    localparam int PWR_CNT_W = 16;
    // Reset value and lane-enable masks.
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    // Output drive state.
    typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITTEN, SBS_SLEEP} sbs_state_t;
endpackage
`default_nettype wire

// ===== core/sbsram_fifo.sv
`default_nettype none
module sbsram_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    // Handshake and pointer arithmetic.
    always_comb begin
        push = inValid && inReady;
        pop = outValid && outReady;
        wrPtr_nxt = push ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
        rdPtr_nxt = pop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
        count_nxt = (AW + 1)'(count_r + (AW + 1)'(push) - (AW + 1)'(pop));
    end

    assign inReady = (count_r != (AW + 1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];

    // Storage and pointer registers.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== test/sbsram_ctrl_model.sv
`default_nettype none
// --------------------------------------------
// Bus controller model
// --------------------------------------------
module sbsram_ctrl_model (
    input wire logic clk,
    input wire logic powerReady,
    output logic [2:0] sel,
    output logic procStb_n,
    output logic ctrlStb_n,
    output logic gwN,
    output logic gateN,
    output logic [sbsram_pkg::LANES-1:0] lanesN,
    output logic sleepReq,
    output logic [sbsram_pkg::ADDR_W-1:0] addr,
    output logic [sbsram_pkg::DATA_W-1:0] dataIn
);
    // Start deselected with both strobes idle.
    initial begin
        {sel, procStb_n, ctrlStb_n, gwN, gateN} = 7'h7F;
        {lanesN, sleepReq, addr, dataIn} = '0;
    end
    // Release the bus; data flips so a stale value is never mistaken for a live one.
    task automatic idle();
        @(posedge clk);
        {sel, procStb_n, ctrlStb_n, gwN, gateN} <= 7'h7F;
        dataIn <= ~dataIn;
    endtask
    task automatic access(input logic [2:0] s, input logic prc, input logic [1:0] wc,
        input logic [3:0] ln, input logic [5:0] a, input logic [31:0] d);
        while (powerReady !== 1'b1) @(posedge clk);
        @(posedge clk);
        {sel, procStb_n, ctrlStb_n, gwN, gateN} <= {s, ~prc, prc, wc};
        {lanesN, addr, dataIn} <= {ln, a, d};
        idle();
    endtask
    // sleep entered with the select given by the caller.
    task automatic doze(input int n, input logic [2:0] s);
        @(posedge clk);
        sel <= s;
        sleepReq <= 1'b1;
        repeat (n) @(posedge clk);
        sleepReq <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/sbsram_core_tb_top.sv
`default_nettype none
// --------------------------------------------
// Testbench
// --------------------------------------------
module sbsram_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] s; logic [1:0] wc; logic [3:0] ln; logic [5:0] a;
        logic [31:0] d; logic o; logic [31:0] q;
    } sbsram_row_t;
    logic clk, srst, outEnable_n, procStb_n, ctrlStb_n, gwN, gateN, sleepReq;
    logic dataOe, writeStall, powerReady, sleepViolation, hit;
    logic [2:0] sel;
    logic [3:0] lanesN;
    logic [5:0] addr;
    logic [31:0] dataIn, dataOut;
    int failCount = 0, nCompared = 0, cycles = 0;
    // Select, write controls, lanes, address, data, expected drive, expected read-back.
    // A deselected cycle leaves the drive of the preceding read standing.
    sbsram_row_t rows [0:6] = '{
        '{3'h2, 2'h1, 4'hF, 6'h01, 32'h11223344, 1'b0, 32'h11223344},
        '{3'h2, 2'h2, 4'h0, 6'h02, 32'hAABBCCDD, 1'b0, 32'hAABBCCDD},
        '{3'h2, 2'h2, 4'h5, 6'h01, 32'h55667788, 1'b0, 32'h55227744},
        '{3'h2, 2'h3, 4'h0, 6'h02, 32'h00000000, 1'b1, 32'hAABBCCDD},
        '{3'h6, 2'h0, 4'h0, 6'h02, 32'h00000000, 1'b1, 32'hAABBCCDD},
        '{3'h0, 2'h0, 4'h0, 6'h02, 32'h00000000, 1'b1, 32'hAABBCCDD},
        '{3'h3, 2'h0, 4'h0, 6'h02, 32'h00000000, 1'b1, 32'hAABBCCDD}};
    sbsram_core u_sbsram_core (.clk(clk), .srst(srst), .primary_select_n(sel[2]),
        .depth_select_hi(sel[1]), .depth_select_lo_n(sel[0]),
        .proc_addr_strobe_n(procStb_n), .ctrl_addr_strobe_n(ctrlStb_n),
        .global_write_n(gwN), .byte_write_gate_n(gateN), .lane_write_n(lanesN),
        .outEnable_n(outEnable_n), .sleep_request(sleepReq), .addr(addr),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .writeStall(writeStall),
        .powerReady(powerReady), .sleepViolation(sleepViolation));
    sbsram_ctrl_model u_sbsram_ctrl_model (.clk(clk), .powerReady(powerReady),
        .sel(sel), .procStb_n(procStb_n), .ctrlStb_n(ctrlStb_n), .gwN(gwN),
        .gateN(gateN), .lanesN(lanesN), .sleepReq(sleepReq), .addr(addr),
        .dataIn(dataIn));
    // Free-running clock at 100 ns.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard sized for the power wait plus the tests.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            $display("BAD %0t timeout", $time);
            finalReport();
        end
    end
    task automatic chkBit(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %0t word %h exp %h", $time, got, exp);
        end
    endtask
    // Read one word and check the bus afterwards.
    task automatic rd(input logic prc, input logic [5:0] a, input logic [31:0] q);
        u_sbsram_ctrl_model.access(3'h2, prc, 2'h3, 4'hF, a, 32'h0);
        @(posedge clk) #1;
        chkBit(dataOe, 1'b1);
        chkWord(dataOut, q);
    endtask
    task automatic finalReport();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Reset, table of writes, reads and deselected accesses with read-back, then the awkward cases.
    initial begin
        srst = 1'b1;
        outEnable_n = 1'b0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        #1 chkBit(powerReady, 1'b0);
        // The wait ends on the ten-thousandth edge after release.
        repeat (9999) @(posedge clk);
        #1 chkBit(powerReady, 1'b0);
        @(posedge clk) #1;
        chkBit(powerReady, 1'b1);
        foreach (rows[i]) begin
            u_sbsram_ctrl_model.access(rows[i].s, 1'b0, rows[i].wc, rows[i].ln,
                rows[i].a, rows[i].d);
            @(posedge clk) #1;
            chkBit(dataOe, rows[i].o);
            repeat (3) @(posedge clk);
            rd(1'b1, rows[i].a, rows[i].q);
        end
        chkBit(writeStall, 1'b0);
        @(posedge clk) outEnable_n <= 1'b1;
        @(posedge clk) #1;
        chkBit(dataOe, 1'b0);
        @(posedge clk) outEnable_n <= 1'b0;
        rd(1'b0, 6'h01, 32'h55227744);
        u_sbsram_ctrl_model.doze(5, 3'h6);
        repeat (2) @(posedge clk) #1;
        chkBit(dataOe, 1'b0);
        chkBit(sleepViolation, 1'b0);
        u_sbsram_ctrl_model.doze(1, 3'h2);
        // The flag is a one-cycle pulse, so the first look is just after the request edge.
        hit = 1'b0;
        repeat (3) begin
            #1 hit |= (sleepViolation === 1'b1);
            @(posedge clk);
        end
        chkBit(hit, 1'b1);
        u_sbsram_ctrl_model.idle();
        rd(1'b1, 6'h02, 32'hAABBCCDD);
        finalReport();
    end
endmodule
`default_nettype wire
